/* File: gfcs_pkg.sv */
// Constants and types for the gas heat and cooling sequencer.
// Assumes a single free-running system clock; all timing is in whole seconds.
package gfcs_pkg;
    // ------------------------------------------------------------
    // Clock and second base
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int SEC_S = 1;
    localparam int SEC_CYC = CLK_HZ * SEC_S; // Cycles in one second
    // ------------------------------------------------------------
    // Sequence times in seconds
    // ------------------------------------------------------------
    localparam logic [11:0] POWERUP_S = 12'h002;
    localparam logic [11:0] HEAT_DLY_S = 12'h001;
    localparam logic [11:0] PS_WARN_S = 12'h005;
    localparam logic [11:0] PS_GIVEUP_S = 12'h03C;
    localparam logic [11:0] IND_OFF_S = 12'h03C;
    localparam logic [11:0] PREPURGE_S = 12'h00F;
    localparam logic [11:0] IGN_S = 12'h005;
    localparam logic [11:0] PROOF_S = 12'h002;
    localparam logic [11:0] TRIAL_S = 12'h007;
    localparam logic [11:0] LOCK_PURGE_S = 12'h00F;
    localparam logic [11:0] HTAP_S = 12'h01E;
    localparam logic [11:0] POSTPURGE_S = 12'h00F;
    localparam logic [11:0] PS_SHORT_S = 12'h002;
    localparam logic [11:0] COOL_DLY_S = 12'h001;
    localparam logic [11:0] COOL_OFF_S = 12'h03C;
    localparam logic [11:0] SOL_DLY_S = 12'h001;
    localparam logic [11:0] SOFTLOCK_S = 12'hE10;
    localparam logic [11:0] BO_60_S = 12'h03C;
    localparam logic [11:0] BO_90_S = 12'h05A;
    localparam logic [11:0] BO_120_S = 12'h078;
    localparam logic [11:0] BO_180_S = 12'h0B4;
    // ------------------------------------------------------------
    // Event limits and flash codes
    // ------------------------------------------------------------
    localparam logic [2:0] IGN_MAX = 3'h3;
    localparam logic [2:0] EVT_MAX = 3'h5;
    localparam logic [3:0] CODE_CHECK = 4'h2;
    localparam logic [3:0] CODE_PS = 4'h3;
    localparam logic [3:0] CODE_LIMIT = 4'h4;
    localparam logic [3:0] CODE_NOFAN = 4'h4;
    localparam logic [3:0] CODE_FLAME = 4'h6;
    localparam logic [3:0] CODE_IGN = 4'h7;
    localparam logic [5:0] HEART_PER = 6'h04;
    localparam logic [5:0] FLASH_GAP = 6'h03;
    typedef enum logic [3:0] {H_IDLE, H_DELAY, H_CHECK, H_PROVE, H_INDOFF, H_PRE,
        H_TRIAL, H_RUN, H_POST, H_LPURGE, H_SOFT} gfcs_heat_type;
    typedef enum logic [2:0] {DUTY_OFF, DUTY_FAN, DUTY_COOL1, DUTY_COOL2,
        DUTY_HEAT} gfcs_duty_type;
endpackage

/* File: gfcs_top.sv */
// Sequencer for a packaged gas heat and cooling unit: calls, burner, blower, LED.
// Assumes thermostat and safety inputs are asynchronous contacts, already debounced.
`timescale 1ns/1ps
module gfcs_top import gfcs_pkg::*; #(
    parameter int SEC_CYCLES = SEC_CYC
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Thermostat calls
    input wire logic fan_call,
    input wire logic first_cool_stage_call,
    input wire logic second_cool_stage_call,
    input wire logic heat_call,
    // Safety inputs and field setting
    input wire logic pressure_closed,
    input wire logic limit_closed,
    input wire logic flame_valid,
    input wire logic gas_valve_open,
    input wire logic [1:0] off_delay_sel,
    // Burner outputs
    output logic inducer,
    output logic gas_valve,
    output logic igniter,
    // Blower and compressor outputs
    output logic fan_only_motor_tap,
    output logic cool_motor_tap,
    output logic heat_motor_tap,
    output logic contactor,
    output logic capacity_solenoid,
    output gfcs_duty_type duty_command,
    // Status LED
    output logic led_green,
    output logic led_red
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [8:0] sync1, sync2;
    logic y1_c, y2_c, heat_c, ps_c, lim_c, flame_c, gvs_c;
    logic [1:0] sel_c;
    // Two stages on every pin; first stage feeds only the second
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (clk_en) begin
            sync1 <= {off_delay_sel, gas_valve_open, flame_valid, limit_closed,
                pressure_closed, heat_call, second_cool_stage_call, first_cool_stage_call};
            sync2 <= sync1;
        end
    end
    assign {sel_c, gvs_c, flame_c, lim_c, ps_c, heat_c, y2_c, y1_c} = sync2;
    // ------------------------------------------------------------
    // Second tick and power-up check
    // ------------------------------------------------------------
    logic [31:0] div, next_div;
    logic [11:0] pu, next_pu;
    logic tick;
    // Fan call rides in bit 0 of a separate stage so widths stay honest
    logic fan_s1, fan_s2;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fan_s1 <= 1'b0;
            fan_s2 <= 1'b0;
        end else if (clk_en) begin
            fan_s1 <= fan_call;
            fan_s2 <= fan_s1;
        end
    end
    assign tick = clk_en && (div == 32'(SEC_CYCLES - 1));
    wire pu_done = (pu >= POWERUP_S);
    always_comb begin
        next_div = tick ? '0 : div + 32'h1;
        next_pu = (tick && !pu_done) ? pu + 12'h1 : pu;
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div <= '0;
            pu <= '0;
        end else if (clk_en) begin
            div <= next_div;
            pu <= next_pu;
        end
    end
    // ------------------------------------------------------------
    // Heating sequence
    // ------------------------------------------------------------
    gfcs_heat_type hst, next_hst;
    logic [11:0] hsec, next_hsec, bo, next_bo, gvs, next_gvs;
    logic [11:0] flsec, next_flsec, pss, next_pss, bo_sel;
    logic [2:0] ign, next_ign, psn, next_psn, fln, next_fln, lmn, next_lmn;
    logic [3:0] lock_code, next_lock;
    logic hblow, next_hblow, prev_call, next_prev_call, stop_blow, call;
    logic next_gas, next_ind, next_ign_out;
    // Only proceed once power-up check is over
    assign call = heat_c && pu_done;
    wire pre_ok = lim_c && !gvs_c && !ps_c;
    // Strap is read only through its synchroniser, never straight off the pin
    always_comb begin
        case (sel_c)
            2'h0: bo_sel = BO_60_S;
            2'h1: bo_sel = BO_90_S;
            2'h2: bo_sel = BO_120_S;
            default: bo_sel = BO_180_S;
        endcase
    end
    always_comb begin
        next_hst = hst;
        next_hsec = (tick && hsec != 12'hFFF) ? hsec + 12'h1 : hsec;
        next_bo = (tick && bo != 12'h0) ? bo - 12'h1 : bo;
        next_gvs = gvs;
        next_flsec = flsec;
        next_pss = ps_c ? 12'h0 : pss;
        next_ign = ign;
        next_psn = psn;
        next_fln = fln;
        next_lmn = lmn;
        next_lock = lock_code;
        next_hblow = hblow;
        next_prev_call = call;
        stop_blow = 1'b0;
        // Fresh call wipes the event history
        if (call && !prev_call && hst == H_IDLE) begin
            next_ign = '0;
            next_psn = '0;
            next_fln = '0;
            next_lmn = '0;
        end
        case (hst)
            H_IDLE: if (call) next_hst = H_DELAY;
            H_DELAY: begin
                if (!call) next_hst = H_IDLE;
                else if (hsec >= HEAT_DLY_S) next_hst = H_CHECK;
            end
            H_CHECK: begin
                // Held here while any precondition fails
                if (!call) next_hst = H_IDLE;
                else if (pre_ok) next_hst = H_PROVE;
            end
            H_PROVE: begin
                if (!call) next_hst = H_POST;
                else if (ps_c) next_hst = H_PRE;
                else if (hsec >= PS_GIVEUP_S) next_hst = H_INDOFF;
            end
            H_INDOFF: if (hsec >= IND_OFF_S) next_hst = call ? H_CHECK : H_IDLE;
            H_PRE: begin
                next_flsec = '0;
                if (!call) next_hst = H_POST;
                else if (hsec >= PREPURGE_S) next_hst = H_TRIAL;
            end
            H_TRIAL: begin
                if (!flame_c) next_flsec = '0;
                else if (tick) next_flsec = flsec + 12'h1;
                if (!call) next_hst = H_POST;
                // Spark runs its full time before the proven flame is accepted
                else if (flsec >= PROOF_S && hsec >= IGN_S) next_hst = H_RUN;
                else if (hsec >= TRIAL_S) begin
                    next_ign = ign + 3'h1;
                    if (ign + 3'h1 >= IGN_MAX) begin
                        next_lock = CODE_IGN;
                        next_hst = H_LPURGE;
                    end else begin
                        next_hst = H_PRE;
                    end
                end
            end
            H_RUN: begin
                if (!call) begin
                    next_hst = H_POST;
                    stop_blow = 1'b1;
                end else if (!lim_c) begin
                    stop_blow = 1'b1;
                    next_lmn = lmn + 3'h1;
                    if (lmn + 3'h1 >= EVT_MAX) begin
                        next_lock = CODE_LIMIT;
                        next_hst = H_LPURGE;
                    end else begin
                        next_hst = H_CHECK;
                    end
                end else if (!ps_c && (pss >= PS_SHORT_S || !flame_c)) begin
                    stop_blow = 1'b1;
                    next_psn = psn + 3'h1;
                    if (psn + 3'h1 >= EVT_MAX) begin
                        next_lock = CODE_PS;
                        next_hst = H_LPURGE;
                    end else begin
                        next_hst = H_PROVE;
                    end
                end else if (!flame_c) begin
                    stop_blow = 1'b1;
                    next_fln = fln + 3'h1;
                    if (fln + 3'h1 >= EVT_MAX) begin
                        next_lock = CODE_FLAME;
                        next_hst = H_LPURGE;
                    end else begin
                        next_hst = H_PROVE;
                    end
                end else if (!ps_c && tick) begin
                    next_pss = pss + 12'h1;
                end
            end
            H_POST: if (hsec >= POSTPURGE_S) next_hst = H_IDLE;
            H_LPURGE: if (hsec >= LOCK_PURGE_S) next_hst = H_SOFT;
            H_SOFT: begin
                if (hsec >= SOFTLOCK_S) begin
                    next_hst = H_IDLE;
                    next_lock = '0;
                    next_ign = '0;
                end
            end
            default: next_hst = H_IDLE;
        endcase
        if (next_hst != hst) next_hsec = '0;
        // Blower keeps running through its off delay after any stop
        if (stop_blow || (hblow && !call)) begin
            next_hblow = 1'b0;
            next_bo = bo_sel;
        end
        next_gas = (next_hst == H_TRIAL || next_hst == H_RUN) && ps_c;
        next_ign_out = next_gas && (next_hst == H_TRIAL) && (next_hsec < IGN_S);
        next_ind = next_hst inside {H_PROVE, H_PRE, H_TRIAL, H_RUN, H_POST, H_LPURGE};
        if (!next_gas || next_hst == H_IDLE) next_gvs = next_gas ? gvs : '0;
        if (next_gas && tick && gvs < HTAP_S) next_gvs = gvs + 12'h1;
        if (gvs >= HTAP_S && hst == H_RUN && call) next_hblow = 1'b1;
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hst <= H_IDLE;
            {hsec, bo, gvs, flsec, pss} <= '0;
            {ign, psn, fln, lmn, lock_code} <= '0;
            {hblow, prev_call, gas_valve, inducer, igniter} <= '0;
        end else if (clk_en) begin
            hst <= next_hst;
            hsec <= next_hsec;
            bo <= next_bo;
            gvs <= next_gvs;
            flsec <= next_flsec;
            pss <= next_pss;
            ign <= next_ign;
            psn <= next_psn;
            fln <= next_fln;
            lmn <= next_lmn;
            lock_code <= next_lock;
            hblow <= next_hblow;
            prev_call <= next_prev_call;
            gas_valve <= next_gas;
            inducer <= next_ind;
            igniter <= next_ign_out;
        end
    end
    // ------------------------------------------------------------
    // Fan, cooling and blower duty
    // ------------------------------------------------------------
    logic [11:0] cd, next_cd, coff, next_coff, c2off, next_c2off;
    logic cool_req, c_on;
    gfcs_duty_type next_duty;
    assign cool_req = y1_c && !heat_c && pu_done;
    assign c_on = cool_req && cd >= COOL_DLY_S;
    always_comb begin
        next_cd = !cool_req ? '0 : ((tick && cd < COOL_DLY_S) ? cd + 12'h1 : cd);
        next_coff = c_on ? COOL_OFF_S : ((tick && coff != 0) ? coff - 12'h1 : coff);
        next_c2off = (c_on && y2_c) ? COOL_OFF_S
            : ((tick && c2off != 0) ? c2off - 12'h1 : c2off);
        // Warm-up leaves duty to the cooling or fan calls until heat blower is due
        if (hblow || bo != 0) next_duty = DUTY_HEAT;
        else if (c2off != 0) next_duty = DUTY_COOL2;
        else if (coff != 0) next_duty = DUTY_COOL1;
        else if (fan_s2 && pu_done) next_duty = DUTY_FAN;
        else next_duty = DUTY_OFF;
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {cd, coff, c2off} <= '0;
            duty_command <= DUTY_OFF;
            {fan_only_motor_tap, cool_motor_tap, heat_motor_tap} <= '0;
            {contactor, capacity_solenoid} <= '0;
        end else if (clk_en) begin
            cd <= next_cd;
            coff <= next_coff;
            c2off <= next_c2off;
            duty_command <= next_duty;
            fan_only_motor_tap <= fan_s2 && pu_done;
            cool_motor_tap <= next_coff != 0;
            heat_motor_tap <= next_hblow || next_bo != 0;
            contactor <= cool_req;
            capacity_solenoid <= cool_req && y2_c && cd >= SOL_DLY_S;
        end
    end
    // ------------------------------------------------------------
    // Status LED
    // ------------------------------------------------------------
    logic [5:0] pos, next_pos, per;
    logic [3:0] code;
    logic solid, grn, red, next_g, next_r;
    always_comb begin
        solid = 1'b0;
        code = '0;
        grn = 1'b1;
        red = 1'b0;
        if (!pu_done) solid = 1'b1;
        else if (hst == H_SOFT || hst == H_LPURGE) begin
            code = lock_code;
            grn = 1'b0;
            red = 1'b1;
        end else if ((hst == H_PROVE && hsec >= PS_WARN_S) || hst == H_INDOFF) begin
            code = CODE_PS;
            grn = 1'b0;
            red = 1'b1;
        end else if (hst == H_CHECK) begin
            code = CODE_CHECK;
            grn = 1'b0;
            red = 1'b1;
        end else if (y1_c && !fan_s2) begin
            code = CODE_NOFAN;
            red = 1'b1;
        end else if (!(hst == H_IDLE && !y1_c && !fan_s2 && !heat_c)) solid = 1'b1;
        per = (code == 0) ? HEART_PER : {1'b0, code, 1'b0} + FLASH_GAP;
        next_pos = tick ? ((pos + 6'h1 >= per) ? '0 : pos + 6'h1) : pos;
        if (solid) begin
            next_g = grn;
            next_r = red;
        end else if (code == 0) begin
            next_g = pos < 6'h02;
            next_r = 1'b0;
        end else begin
            next_g = grn && !pos[0] && pos < {1'b0, code, 1'b0};
            next_r = red && !pos[0] && pos < {1'b0, code, 1'b0};
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos <= '0;
            led_green <= 1'b0;
            led_red <= 1'b0;
        end else if (clk_en) begin
            pos <= next_pos;
            led_green <= next_g;
            led_red <= next_r;
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    pu_green_a: assert property (!pu_done && $past(!pu_done) && $past(clk_en) && !$past(sys_rst)
        |-> led_green && !led_red) else $error("power-up LED not green");
    fan_follow_a: assert property (clk_en && fan_s2 && pu_done |=> fan_only_motor_tap) else $error("fan tap late");
    pre_hold_a: assert property (hst == H_CHECK && clk_en && !pre_ok |=> hst inside {H_CHECK, H_IDLE}) else $error("inducer started unsafe");
    ign_gas_a: assert property (igniter |-> gas_valve && hsec < IGN_S) else $error("igniter outside trial");
    htap_a: assert property ($rose(heat_motor_tap) && bo == 12'h000 |-> gvs >= HTAP_S) else $error("heat tap early");
    gas_drop_a: assert property (hst == H_RUN && !call && clk_en |=> !gas_valve) else $error("gas held after call drop");
    lock_off_a: assert property (hst == H_SOFT |-> !gas_valve && !inducer) else $error("burner on in lockout");
    ign_cnt_a: assert property (ign <= IGN_MAX && psn <= EVT_MAX) else $error("event count overrun");
    sol_a: assert property (capacity_solenoid |-> contactor) else $error("solenoid without contactor");
    run_c: cover property (hst == H_TRIAL ##1 hst == H_RUN);
    lock_c: cover property (hst == H_LPURGE ##1 hst == H_SOFT);
    cool_c: cover property (cool_motor_tap && duty_command == DUTY_COOL2);
endmodule

/* File: gfcs_plant.sv */
// Behavioural burner plant: pressure switch, flame sensor, valve sense, limit.
// Assumes the sequencer outputs are registered levels on the rising clock edge.
`timescale 1ns/1ps
module gfcs_plant (
    // Clock
    input wire logic sys_clk,
    // Sequencer outputs
    input wire logic inducer,
    input wire logic gas_valve,
    // Bench controls
    input wire logic flame_ok,
    input wire logic [7:0] press_dly,
    // Sensed levels back to the sequencer
    output logic pressure_closed,
    output logic flame_valid,
    output logic gas_valve_open,
    output logic limit_closed
);
    logic [7:0] run_cnt = 8'h00;
    // Switch closes only after the draft builds, opens at once when inducer stops
    always @(negedge sys_clk) begin
        run_cnt <= inducer ? ((run_cnt == 8'hFF) ? run_cnt : run_cnt + 8'h01) : 8'h00;
        pressure_closed <= inducer && (run_cnt >= press_dly);
        flame_valid <= gas_valve && flame_ok;
        gas_valve_open <= gas_valve;
        limit_closed <= 1'b1;
    end
    initial begin
        pressure_closed = 1'b0;
        flame_valid = 1'b0;
        gas_valve_open = 1'b0;
        limit_closed = 1'b1;
    end
endmodule

/* File: tb.sv */
// Self-checking bench for the heat and cooling sequencer.
// Assumes a second base of 8 cycles so every timed step fits a short run.
`timescale 1ns/1ps
module tb import gfcs_pkg::*;;
    logic sys_clk, sys_rst = 1'b1, fan_call = 1'b0, heat_call = 1'b0, flame_ok = 1'b1;
    logic first_cool_stage_call = 1'b0, second_cool_stage_call = 1'b0;
    logic [1:0] off_delay_sel = 2'h0;
    logic [7:0] press_dly = 8'h08;
    logic inducer, gas_valve, igniter, fan_only_motor_tap, cool_motor_tap, heat_motor_tap;
    logic contactor, capacity_solenoid, led_green, led_red, p;
    logic pressure_closed, limit_closed, flame_valid, gas_valve_open;
    gfcs_duty_type duty_command;
    int fail_count = 0, n_compared = 0, seed = 99, n, t, k;
    // ----------------------------------------
    // Clock, design and plant
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    gfcs_top #(.SEC_CYCLES(8)) dut (.sys_clk, .sys_rst, .clk_en(1'b1), .fan_call,
        .first_cool_stage_call, .second_cool_stage_call, .heat_call, .pressure_closed,
        .limit_closed, .flame_valid, .gas_valve_open, .off_delay_sel, .inducer, .gas_valve,
        .igniter, .fan_only_motor_tap, .cool_motor_tap, .heat_motor_tap, .contactor,
        .capacity_solenoid, .duty_command, .led_green, .led_red);
    gfcs_plant plant (.sys_clk, .inducer, .gas_valve, .flame_ok, .press_dly, .pressure_closed,
        .flame_valid, .gas_valve_open, .limit_closed);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
            fail_count++;
        end
    endtask
    // Tolerance of a tick and a half covers divider phase and input sync
    task automatic near(input string nm, input int c, input int ticks);
        check(nm, c >= ticks * 8 - 12 && c <= ticks * 8 + 12, 1);
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return inducer;
            1: return gas_valve;
            2: return igniter;
            3: return fan_only_motor_tap;
            4: return cool_motor_tap;
            5: return heat_motor_tap;
            6: return led_red;
            7: return pressure_closed;
            default: return capacity_solenoid;
        endcase
    endfunction
    // Bounded wait, counted in falling edges where outputs are settled
    task automatic wait_sig(input int s, input logic v, output int c);
        c = 0;
        while (sig(s) !== v && c < 20000) begin
            @(negedge sys_clk);
            c++;
        end
        if (c >= 20000) begin
            fail_count++;
            wrap_up();
        end
    endtask
    function automatic int bo(input logic [1:0] s);
        case (s)
            2'h0: return BO_60_S;
            2'h1: return BO_90_S;
            2'h2: return BO_120_S;
            default: return BO_180_S;
        endcase
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        check("pwr_green", led_green, 1);
        repeat (40) @(negedge sys_clk);
        n = 0;
        for (k = 0; k < 64; k++) begin
            @(negedge sys_clk);
            n += led_green;
        end
        check("heartbeat", n, 32);
        check("idle_out", {inducer, gas_valve, fan_only_motor_tap, cool_motor_tap}, 0);
        fan_call = 1'b1;
        wait_sig(3, 1, n);
        check("fan_on", n >= 2 && n <= 4, 1);
        fan_call = 1'b0;
        wait_sig(3, 0, n);
        check("fan_off", n >= 2 && n <= 4, 1);
        // Both cooling stages without fan: blower still runs, amber code shows
        first_cool_stage_call = 1'b1;
        second_cool_stage_call = 1'b1;
        wait_sig(4, 1, n);
        check("cool_dly", n <= 20, 1);
        check("contactor", contactor, 1);
        wait_sig(8, 1, n);
        check("solenoid", n <= 16, 1);
        // Duty register follows the stage hold counter one cycle later
        @(negedge sys_clk);
        check("duty2", duty_command, DUTY_COOL2);
        wait_sig(6, 1, n);
        check("amber", led_green, 1);
        first_cool_stage_call = 1'b0;
        second_cool_stage_call = 1'b0;
        wait_sig(4, 0, n);
        near("cool_off", n, 60);
        // Normal heat cycle with random switch lag and blower delay
        press_dly = 8'(4 + $unsigned($random(seed)) % 24);
        off_delay_sel = 2'($random(seed));
        heat_call = 1'b1;
        wait_sig(0, 1, n);
        check("ind_dly", n <= 40, 1);
        wait_sig(7, 1, n);
        wait_sig(1, 1, n);
        near("prepurge", n, 15);
        check("ign_with_gas", igniter, 1);
        wait_sig(2, 0, t);
        near("ign_time", t, 5);
        check("gas_hold", gas_valve, 1);
        wait_sig(5, 1, n);
        near("heat_tap", t + n, 30);
        heat_call = 1'b0;
        wait_sig(1, 0, t);
        check("gas_drop", t <= 5, 1);
        wait_sig(0, 0, n);
        near("postpurge", t + n, 15);
        wait_sig(5, 0, k);
        near("blower_off", t + n + k, bo(off_delay_sel));
        // No flame: three trials, then purge, red code and soft lockout
        flame_ok = 1'b0;
        heat_call = 1'b1;
        for (k = 0; k < 3; k++) begin
            wait_sig(1, 1, n);
            wait_sig(1, 0, n);
        end
        near("trial", n, TRIAL_S);
        wait_sig(0, 0, n);
        near("lock_purge", n, 15);
        wait_sig(6, 1, n);
        n = 0;
        p = 1'b1;
        for (k = 0; k < 136; k++) begin
            @(negedge sys_clk);
            n += (led_red && !p);
            p = led_red;
        end
        check("red_flashes", n >= 6 && n <= 7, 1);
        check("soft_lock", {gas_valve, inducer}, 0);
        heat_call = 1'b0;
        wrap_up();
    end
endmodule
